/* src/flrec_pkg.sv */
package flrec_pkg;

  // Command codes
  localparam logic [7:0] CMD_LOG_READBACK = 8'hee;
  localparam logic [7:0] CMD_LOG_FORCE_CAPTURE = 8'hea;
  localparam logic [7:0] CMD_LOG_ERASE_UNLOCK = 8'hec;
  localparam logic [7:0] CMD_PEAK_RESET = 8'hdd;

  // Log layout
  localparam int LOG_LEN = 147;
  localparam logic [7:0] LOG_LEN_BYTE = 8'h93;
  localparam logic [7:0] LOG_EMPTY_BYTE = 8'h00;
  localparam int HDR_LEN = 27;
  localparam int EVT_LEN = 20;
  localparam int EVT_NUM = 6;
  localparam int EVT_KEPT_NVM = 4;
  localparam logic [7:0] OFS_CAUSE = 8'h00;
  localparam logic [7:0] OFS_TIME0 = 8'h01;
  localparam logic [7:0] OFS_TIME5 = 8'h06;
  localparam logic [7:0] OFS_VPK_HI = 8'h07;
  localparam logic [7:0] OFS_VPK_LO = 8'h08;
  localparam logic [7:0] OFS_IPK_HI = 8'h0b;
  localparam logic [7:0] OFS_IPK_LO = 8'h0c;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;

  // Status and configuration bits
  localparam int CFG_LOG_EN_BIT = 7;
  localparam int STAT_LOG_BIT = 3;

  // Temperature inhibit, whole degrees
  localparam logic signed [15:0] TEMP_HI_C = 16'sd130;
  localparam logic signed [15:0] TEMP_LO_C = 16'sd125;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 200;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int SWEEP_LAST = 25;
  localparam int PWRUP_MS = 1000;
  localparam int PWRUP_TICKS = PWRUP_MS * 1000 / TICK_US;

  // Buffer
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;

  typedef struct packed {
    logic [7:0] cause;
    logic [47:0] uptime;
    logic [15:0] vpk;
    logic [15:0] ipk;
  } flrec_hdr_type;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } flrec_cmd_type;

endpackage : flrec_pkg

/* src/flrec_fifo.sv */
`timescale 1ns/100ps
module flrec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_flush,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    push = i_in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop = i_out_ready && (cnt_q != '0);
    wp_d = wp_q + AW'(push);
    rp_d = rp_q + AW'(pop);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (i_flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wp_q] <= i_in_data;
    end
  end

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rp_q];
endmodule : flrec_fifo

/* src/flrec_top.sv */
`timescale 1ns/100ps
module flrec_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Decoded bus command and read pacing
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_rd_ready,
  // Link clock, sampled only
  input wire logic i_link_clk,
  // Fault sources and telemetry
  input wire logic i_fault,
  input wire logic [7:0] i_fault_cause,
  input wire logic [7:0] i_mux_step,
  input wire logic [15:0] i_vout,
  input wire logic [15:0] i_iout,
  input wire logic signed [15:0] i_die_temp,
  input wire logic [7:0] i_cfg_all,
  // Event record sample stream
  input wire logic i_evt_valid,
  input wire logic [flrec_pkg::EVT_LEN*8-1:0] i_evt_data,
  // Non-volatile state restored at power up
  input wire logic i_nvm_present,
  input wire logic i_nvm_locked,
  // Read answer stream
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_rd_last,
  // Status
  output logic [7:0] o_status_vendor,
  output logic o_pwm_fault_off,
  output logic o_log_present,
  output logic o_log_locked,
  output logic o_capture_busy,
  output logic o_temp_inhibit,
  output logic o_link_edge
);
  localparam int EVT_W = flrec_pkg::EVT_LEN * 8;

  // ***************
  // Input sampling
  // ***************
  logic [1:0] lclk_sync_q;
  logic lclk_prev_q;
  logic [3:0] nvm_sync_q;
  always_ff @(posedge i_clk) begin
    lclk_sync_q <= {lclk_sync_q[0], i_link_clk};
    lclk_prev_q <= lclk_sync_q[1];
    nvm_sync_q <= {nvm_sync_q[1:0] , i_nvm_present, i_nvm_locked} ;
  end

  // ***************
  // Uptime and peaks
  // ***************
  logic [14:0] tick_cnt_q, tick_cnt_d;
  logic [47:0] uptime_ticks_q, uptime_ticks_d;
  logic [15:0] peak_out_voltage_q, peak_out_voltage_d;
  logic [15:0] peak_out_current_q, peak_out_current_d;
  logic peak_reset_cmd;
  logic is_cmd_rd, is_cmd_force, is_cmd_erase;

  always_comb begin
    is_cmd_rd = i_cmd_valid && i_cmd_code == flrec_pkg::CMD_LOG_READBACK;
    is_cmd_force = i_cmd_valid && i_cmd_code == flrec_pkg::CMD_LOG_FORCE_CAPTURE;
    is_cmd_erase = i_cmd_valid && i_cmd_code == flrec_pkg::CMD_LOG_ERASE_UNLOCK;
    peak_reset_cmd = i_cmd_valid && i_cmd_code == flrec_pkg::CMD_PEAK_RESET;
    tick_cnt_d = tick_cnt_q + 15'h1;
    uptime_ticks_d = uptime_ticks_q;
    if (tick_cnt_q == 15'(flrec_pkg::TICK_CYC - 1)) begin
      tick_cnt_d = '0;
      uptime_ticks_d = uptime_ticks_q + 48'h1;
    end
    peak_out_voltage_d = (i_vout > peak_out_voltage_q) ? i_vout : peak_out_voltage_q;
    peak_out_current_d = ($signed(i_iout[10:0]) > $signed(peak_out_current_q[10:0]))
                         ? i_iout : peak_out_current_q;
    if (peak_reset_cmd) begin
      peak_out_voltage_d = '0;
      peak_out_current_d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tick_cnt_q <= '0;
      uptime_ticks_q <= '0;
      peak_out_voltage_q <= '0;
      peak_out_current_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      uptime_ticks_q <= uptime_ticks_d;
      peak_out_voltage_q <= peak_out_voltage_d;
      peak_out_current_q <= peak_out_current_d;
    end
  end

  // ***************
  // Circular event record and stored log
  // ***************
  typedef enum logic [3:0] {
    CAP_IDLE = 4'h1,
    CAP_SWEEP = 4'h2,
    CAP_STORE = 4'h4,
    CAP_DONE = 4'h8
  } flrec_cap_type;

  flrec_cap_type cap_q, cap_d;
  logic [EVT_W-1:0] ring_q [flrec_pkg::EVT_NUM];
  logic [2:0] head_q, head_d;
  logic [EVT_W-1:0] nvm_evt_q [flrec_pkg::EVT_NUM];
  logic [2:0] nvm_head_q, nvm_head_d;
  flrec_pkg::flrec_hdr_type hdr_q, hdr_d, snap_q, snap_d;
  logic present_q, present_d, locked_q, locked_d, from_nvm_q, from_nvm_d;
  logic inhibit_q, inhibit_d, stat_bit_q, stat_bit_d, pwm_off_q, pwm_off_d;
  logic restore_q;
  logic trig;

  always_comb begin
    inhibit_d = inhibit_q;
    if (i_die_temp > flrec_pkg::TEMP_HI_C) inhibit_d = 1'b1;
    else if (i_die_temp < flrec_pkg::TEMP_LO_C) inhibit_d = 1'b0;
    trig = i_cfg_all[flrec_pkg::CFG_LOG_EN_BIT] && !locked_q &&
           (i_fault || (is_cmd_force && !inhibit_q));
    cap_d = cap_q;
    head_d = (i_evt_valid) ? ((head_q == 3'(flrec_pkg::EVT_NUM - 1)) ? 3'h0 : head_q + 3'h1)
             : head_q;
    nvm_head_d = nvm_head_q;
    hdr_d = hdr_q;
    snap_d = snap_q;
    present_d = present_q;
    locked_d = locked_q;
    from_nvm_d = from_nvm_q;
    stat_bit_d = stat_bit_q;
    pwm_off_d = pwm_off_q;
    if (is_cmd_force && !inhibit_q && i_cfg_all[flrec_pkg::CFG_LOG_EN_BIT]) begin
      stat_bit_d = 1'b1;
      pwm_off_d = 1'b1;
    end
    unique case (cap_q)
      CAP_IDLE: begin
        if (trig) begin
          snap_d = '{cause: i_fault_cause, uptime: uptime_ticks_q,
                     vpk: peak_out_voltage_q, ipk: peak_out_current_q};
          cap_d = CAP_SWEEP;
        end
      end
      CAP_SWEEP: begin
        if (i_mux_step == 8'(flrec_pkg::SWEEP_LAST)) cap_d = CAP_STORE;
      end
      CAP_STORE: begin
        hdr_d = snap_q;
        nvm_head_d = head_q;
        present_d = 1'b1;
        locked_d = 1'b1;
        from_nvm_d = 1'b0;
        cap_d = CAP_DONE;
      end
      CAP_DONE: cap_d = CAP_IDLE;
      default: cap_d = CAP_IDLE;
    endcase
    if (is_cmd_erase) begin
      present_d = 1'b0;
      locked_d = 1'b0;
      stat_bit_d = 1'b0;
      pwm_off_d = 1'b0;
    end
    if (restore_q) begin
      present_d = nvm_sync_q[3];
      locked_d = nvm_sync_q[2];
      from_nvm_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cap_q <= CAP_IDLE;
      head_q <= '0;
      nvm_head_q <= '0;
      snap_q <= '0;
      present_q <= 1'b0;
      locked_q <= 1'b0;
      from_nvm_q <= 1'b1;
      inhibit_q <= 1'b0;
      stat_bit_q <= 1'b0;
      pwm_off_q <= 1'b0;
      restore_q <= 1'b1;
    end else begin
      cap_q <= cap_d;
      head_q <= head_d;
      nvm_head_q <= nvm_head_d;
      snap_q <= snap_d;
      present_q <= present_d;
      locked_q <= locked_d;
      from_nvm_q <= from_nvm_d;
      inhibit_q <= inhibit_d;
      stat_bit_q <= stat_bit_d;
      pwm_off_q <= pwm_off_d;
      restore_q <= 1'b0;
    end
    // Stored header survives reset like the event store
    hdr_q <= hdr_d;
    if (i_evt_valid) ring_q[head_q] <= i_evt_data;
    if (cap_q == CAP_STORE) begin
      for (int k = 0; k < flrec_pkg::EVT_NUM; k++) nvm_evt_q[k] <= ring_q[k];
    end
  end

  // ***************
  // Readback byte source
  // ***************
  function automatic logic [7:0] log_byte(input logic [7:0] idx);
    logic [7:0] b;
    int e, o, slot;
    b = flrec_pkg::RESERVED_BYTE;
    e = 0;
    o = 0;
    slot = 0;
    if (idx == flrec_pkg::OFS_CAUSE) b = hdr_q.cause;
    else if (idx >= flrec_pkg::OFS_TIME0 && idx <= flrec_pkg::OFS_TIME5)
      b = hdr_q.uptime[8*(idx-flrec_pkg::OFS_TIME0) +: 8];
    else if (idx == flrec_pkg::OFS_VPK_HI) b = hdr_q.vpk[15:8];
    else if (idx == flrec_pkg::OFS_VPK_LO) b = hdr_q.vpk[7:0];
    else if (idx == flrec_pkg::OFS_IPK_HI) b = hdr_q.ipk[15:8];
    else if (idx == flrec_pkg::OFS_IPK_LO) b = hdr_q.ipk[7:0];
    else if (idx >= 8'(flrec_pkg::HDR_LEN)) begin
      e = (int'(idx) - flrec_pkg::HDR_LEN) / flrec_pkg::EVT_LEN;
      o = (int'(idx) - flrec_pkg::HDR_LEN) % flrec_pkg::EVT_LEN;
      if (from_nvm_q && e >= flrec_pkg::EVT_KEPT_NVM) e = flrec_pkg::EVT_KEPT_NVM - 1;
      slot = (int'(nvm_head_q) + flrec_pkg::EVT_NUM - 1 - e) % flrec_pkg::EVT_NUM;
      b = nvm_evt_q[slot][EVT_W-1-8*o -: 8];
    end
    return b;
  endfunction : log_byte

  // ***************
  // Read streamer into FIFO
  // ***************
  logic rd_act_q, rd_act_d;
  logic [7:0] rd_idx_q, rd_idx_d;
  logic rd_cnt_phase_q, rd_cnt_phase_d;
  logic rd_len0_q, rd_len0_d;
  logic [7:0] out_left_q, out_left_d;
  logic f_in_ready, f_in_valid;
  logic [7:0] f_in_data;
  logic f_out_valid;
  logic [7:0] f_out_data;

  always_comb begin
    rd_act_d = rd_act_q;
    rd_idx_d = rd_idx_q;
    rd_cnt_phase_d = rd_cnt_phase_q;
    rd_len0_d = rd_len0_q;
    out_left_d = out_left_q;
    if (i_rd_ready && o_rd_valid) out_left_d = out_left_q - 8'h01;
    f_in_valid = rd_act_q;
    f_in_data = rd_cnt_phase_q ? (rd_len0_q ? flrec_pkg::LOG_EMPTY_BYTE
                                            : flrec_pkg::LOG_LEN_BYTE)
                               : log_byte(rd_idx_q);
    if (is_cmd_rd && !rd_act_q && out_left_q == 8'h00) begin
      rd_act_d = 1'b1;
      rd_cnt_phase_d = 1'b1;
      rd_idx_d = '0;
      rd_len0_d = !present_q || cap_q != CAP_IDLE;
      out_left_d = rd_len0_d ? 8'h01 : 8'(flrec_pkg::LOG_LEN + 1);
    end else if (rd_act_q && f_in_ready) begin
      if (rd_cnt_phase_q) begin
        rd_cnt_phase_d = 1'b0;
        if (rd_len0_q) rd_act_d = 1'b0;
      end else if (rd_idx_q == 8'(flrec_pkg::LOG_LEN - 1)) begin
        rd_act_d = 1'b0;
      end else begin
        rd_idx_d = rd_idx_q + 8'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_act_q <= 1'b0;
      rd_idx_q <= '0;
      rd_cnt_phase_q <= 1'b0;
      rd_len0_q <= 1'b1;
      out_left_q <= 8'h00;
    end else begin
      rd_act_q <= rd_act_d;
      rd_idx_q <= rd_idx_d;
      rd_cnt_phase_q <= rd_cnt_phase_d;
      rd_len0_q <= rd_len0_d;
      out_left_q <= out_left_d;
    end
  end

  flrec_fifo #(.WIDTH(flrec_pkg::FIFO_W), .DEPTH(flrec_pkg::FIFO_D)) u_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_flush(1'b0),
    .i_in_valid(f_in_valid),
    .i_in_data(f_in_data),
    .o_in_ready(f_in_ready),
    .o_out_valid(f_out_valid),
    .o_out_data(f_out_data),
    .i_out_ready(i_rd_ready && o_rd_valid)
  );

  // ***************
  // Registered outputs
  // ***************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
      o_rd_last <= 1'b0;
      o_status_vendor <= '0;
      o_pwm_fault_off <= 1'b0;
      o_log_present <= 1'b0;
      o_log_locked <= 1'b0;
      o_capture_busy <= 1'b0;
      o_temp_inhibit <= 1'b0;
      o_link_edge <= 1'b0;
    end else begin
      o_rd_valid <= f_out_valid && !(i_rd_ready && o_rd_valid);
      o_rd_data <= f_out_data;
      o_rd_last <= f_out_valid && !(i_rd_ready && o_rd_valid) && out_left_d == 8'h01;
      o_status_vendor <= 8'(stat_bit_q) << flrec_pkg::STAT_LOG_BIT;
      o_pwm_fault_off <= pwm_off_q;
      o_log_present <= present_q;
      o_log_locked <= locked_q;
      o_capture_busy <= cap_q != CAP_IDLE;
      o_temp_inhibit <= inhibit_q;
      o_link_edge <= lclk_sync_q[1] && !lclk_prev_q;
    end
  end
endmodule : flrec_top

/* bench/flrec_top_monitor.sv */
`timescale 1ns/100ps
module flrec_top_monitor (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Inputs watched
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_rd_ready,
  input wire logic i_link_clk,
  input wire logic [7:0] i_mux_step,
  input wire logic signed [15:0] i_die_temp,
  input wire logic [7:0] i_cfg_all,
  // Outputs watched
  input wire logic o_rd_valid,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_last,
  input wire logic [7:0] o_status_vendor,
  input wire logic o_log_present,
  input wire logic o_log_locked,
  input wire logic o_capture_busy,
  input wire logic o_temp_inhibit,
  input wire logic o_link_edge
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // *****************************
  // Byte position in a read answer
  // *****************************
  logic [7:0] beat_q;
  logic [7:0] beat_d;
  always_comb begin
    beat_d = beat_q;
    if (o_rd_valid && i_rd_ready) begin
      if ((beat_q == 8'h00 && o_rd_data == 8'h00) || beat_q == 8'h93) begin
        beat_d = 8'h00;
      end else begin
        beat_d = beat_q + 8'h01;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      beat_q <= 8'h00;
    end else begin
      beat_q <= beat_d;
    end
  end
  property p_hold;
    o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("read byte changed before accept");
  property p_gap;
    o_rd_valid && i_rd_ready |=> !o_rd_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap after accepted byte");
  property p_count;
    o_rd_valid && beat_q == 8'h00 |-> o_rd_data inside {8'h00, 8'h93};
  endproperty
  a_count: assert property (p_count) else $error("bad block count");
  property p_last;
    o_rd_valid |-> o_rd_last == ((beat_q == 8'h00 && o_rd_data == 8'h00) || beat_q == 8'h93);
  endproperty
  a_last: assert property (p_last) else $error("last byte flag wrong");
  property p_temp_hi;
    (i_die_temp > 16'sd130) [*4] |-> o_temp_inhibit;
  endproperty
  a_temp_hi: assert property (p_temp_hi) else $error("hot die not inhibited");
  property p_temp_keep;
    (o_temp_inhibit && i_die_temp >= 16'sd125) [*2] |=> o_temp_inhibit;
  endproperty
  a_temp_keep: assert property (p_temp_keep) else $error("inhibit left early");
  property p_erase;
    i_cmd_valid && i_cmd_code == flrec_pkg::CMD_LOG_ERASE_UNLOCK && !o_capture_busy
      |-> ##[1:4] !o_log_locked && !o_log_present && !o_status_vendor[3];
  endproperty
  a_erase: assert property (p_erase) else $error("erase left log or lock");
  property p_sweep;
    $fell(o_capture_busy) |-> $past(i_mux_step, 4) == 8'd25;
  endproperty
  a_sweep: assert property (p_sweep) else $error("capture ended mid sweep");
  property p_status;
    $rose(o_status_vendor[3]) |-> $past(i_cfg_all[7], 2);
  endproperty
  a_status: assert property (p_status) else $error("status set while disabled");
  property p_link;
    !$past(i_link_clk) && i_link_clk |-> ##[1:5] o_link_edge;
  endproperty
  a_link: assert property (p_link) else $error("link edge missed");
  c_full: cover property (o_rd_valid && beat_q == 8'h93);
  c_stall: cover property (o_rd_valid && !i_rd_ready);
  c_hot: cover property (o_temp_inhibit && i_cmd_valid);
endmodule : flrec_top_monitor
bind flrec_top flrec_top_monitor flrec_top_monitor_i (.i_clk(i_clk), .i_srst(i_srst),
  .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_rd_ready(i_rd_ready),
  .i_link_clk(i_link_clk), .i_mux_step(i_mux_step), .i_die_temp(i_die_temp),
  .i_cfg_all(i_cfg_all), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
  .o_rd_last(o_rd_last),
  .o_status_vendor(o_status_vendor), .o_log_present(o_log_present),
  .o_log_locked(o_log_locked), .o_capture_busy(o_capture_busy),
  .o_temp_inhibit(o_temp_inhibit), .o_link_edge(o_link_edge));

/* bench/flrec_host_model.sv */
`timescale 1ns/100ps
module flrec_host_model (
  // Clock and framing
  input wire logic i_clk,
  input wire logic i_frame,
  // Read stream and link clock
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_ready,
  output logic o_link_clk
);
  logic [7:0] got[$];
  initial begin
    o_rd_ready = 1'b0;
    o_link_clk = 1'b0;
    #3.3;
    forever begin
      #80;
      o_link_clk = i_frame ? ~o_link_clk : 1'b0;
    end
  end
  always @(negedge i_clk) begin
    o_rd_ready <= ($urandom % 3) != 0;
  end
  always @(posedge i_clk) begin
    if (i_rd_valid && o_rd_ready) begin
      got.push_back(i_rd_data);
    end
  end
  // Count byte sizes the rest of the read
  function automatic bit done();
    return got.size() > 0 && got.size() == got[0] + 1;
  endfunction : done
endmodule : flrec_host_model

/* bench/test_flrec_top.sv */
`timescale 1ns/100ps
module test_flrec_top;
  logic i_clk = 1'b0, i_srst = 1'b1, i_cmd_valid = 1'b0, i_fault = 1'b0, i_evt_valid = 1'b0;
  logic i_rd_ready, i_link_clk, i_nvm_present = 1'b0, i_nvm_locked = 1'b0, frame = 1'b0;
  logic [7:0] i_cmd_code = 8'h00, i_fault_cause = 8'h00, i_mux_step = 8'h00;
  logic [7:0] i_cfg_all = 8'h00, o_rd_data, o_status_vendor;
  logic [15:0] i_vout = 16'h0000, i_iout = 16'h0000;
  logic signed [15:0] i_die_temp = 16'sd25;
  logic [159:0] i_evt_data = 160'h0;
  logic o_rd_valid, o_rd_last, o_pwm_fault_off, o_log_present, o_log_locked;
  logic o_capture_busy, o_temp_inhibit, o_link_edge;
  int num_errors = 0, comparisons = 0, cyc = 0, vpk, ipk, cause, t;
  int temps[3] = '{131, 127, 124};
  logic [159:0] evs[$];
  int exp_log[$];
  flrec_top flrec_top_i (.i_clk(i_clk), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_code(i_cmd_code), .i_rd_ready(i_rd_ready), .i_link_clk(i_link_clk),
    .i_fault(i_fault), .i_fault_cause(i_fault_cause), .i_mux_step(i_mux_step),
    .i_vout(i_vout), .i_iout(i_iout), .i_die_temp(i_die_temp), .i_cfg_all(i_cfg_all),
    .i_evt_valid(i_evt_valid), .i_evt_data(i_evt_data), .i_nvm_present(i_nvm_present),
    .i_nvm_locked(i_nvm_locked), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_rd_last(o_rd_last), .o_status_vendor(o_status_vendor),
    .o_pwm_fault_off(o_pwm_fault_off), .o_log_present(o_log_present),
    .o_log_locked(o_log_locked), .o_capture_busy(o_capture_busy),
    .o_temp_inhibit(o_temp_inhibit), .o_link_edge(o_link_edge));
  flrec_host_model flrec_host_model_i (.i_clk(i_clk), .i_frame(frame),
    .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .o_rd_ready(i_rd_ready),
    .o_link_clk(i_link_clk));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= i_srst ? 0 : cyc + 1;
  always @(negedge i_clk) i_mux_step <= (i_mux_step == 8'd25) ? 8'd0 : i_mux_step + 8'd1;
  // ***************
  // Shared tasks
  // ***************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic cycles(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cycles
  task automatic cmd(input logic [7:0] c);
    @(negedge i_clk);
    i_cmd_valid = 1'b1;
    i_cmd_code = c;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
  endtask : cmd
  task automatic bounded(input bit busy_wait);
    int n = 0;
    while ((busy_wait ? o_capture_busy !== 1'b0 : !flrec_host_model_i.done()) && n < 4000) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 4000) begin
      num_errors++;
      complete_run();
    end
  endtask : bounded
  task automatic read_log(input int cnt, input bit full);
    flrec_host_model_i.got.delete();
    frame = 1'b1;
    cmd(flrec_pkg::CMD_LOG_READBACK);
    bounded(1'b0);
    cycles(20);
    frame = 1'b0;
    check("count", flrec_host_model_i.got[0], cnt);
    check("length", flrec_host_model_i.got.size(), cnt + 1);
    for (int i = 0; i < 147 && full; i++) begin
      if (exp_log[i] >= 0) check("log byte", flrec_host_model_i.got[i + 1], exp_log[i]);
    end
  endtask : read_log
  // ***************
  // Main sequence
  // ***************
  initial begin
    void'($urandom(7887));
    cycles(2);
    i_srst = 1'b0;
    cycles(6);
    read_log(0, 1'b0);
    cmd(flrec_pkg::CMD_LOG_FORCE_CAPTURE);
    cycles(60);
    check("status disabled", o_status_vendor[3], 1'b0);
    i_cfg_all = 8'h80;
    i_vout = 16'hffff;
    i_iout = 16'h07ff;
    cycles(4);
    i_vout = 16'h0100;
    i_iout = 16'h0010;
    cmd(flrec_pkg::CMD_PEAK_RESET);
    cycles(4);
    vpk = 'h100;
    ipk = 'h10;
    repeat (20) begin
      @(negedge i_clk);
      i_vout = 16'($urandom_range(32767, 256));
      i_iout = 16'($urandom_range(1023, 16));
      if (int'(i_vout) > vpk) vpk = i_vout;
      if (int'(i_iout) > ipk) ipk = i_iout;
    end
    repeat (7) begin
      @(negedge i_clk);
      i_evt_valid = 1'b1;
      i_evt_data = {$urandom, $urandom, $urandom, $urandom, $urandom};
      evs.push_back(i_evt_data);
      @(negedge i_clk);
      i_evt_valid = 1'b0;
    end
    while (cyc < 30000) @(negedge i_clk);
    cause = $urandom_range(255, 1);
    i_fault = 1'b1;
    i_fault_cause = 8'(cause);
    t = cyc / flrec_pkg::TICK_CYC;
    @(negedge i_clk);
    i_fault = 1'b0;
    cycles(5);
    bounded(1'b1);
    check("present", o_log_present, 1'b1);
    check("locked", o_log_locked, 1'b1);
    exp_log = {cause, t, 0, 0, 0, 0, 0, vpk >> 8, vpk & 255, 0, 0, ipk >> 8, ipk & 255};
    repeat (14) exp_log.push_back(-1);
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 20; j++) exp_log.push_back(int'(evs[6 - k][159 - 8 * j -: 8]));
    end
    read_log(147, 1'b1);
    cmd(flrec_pkg::CMD_LOG_ERASE_UNLOCK);
    cycles(6);
    check("unlocked", o_log_locked, 1'b0);
    read_log(0, 1'b0);
    foreach (temps[i]) begin
      i_die_temp = 16'(temps[i]);
      cycles(6);
      cmd(flrec_pkg::CMD_LOG_FORCE_CAPTURE);
      read_log(0, 1'b0);
      bounded(1'b1);
      check("forced status", o_status_vendor[3], temps[i] < 125);
      check("pwm off", o_pwm_fault_off, temps[i] < 125);
    end
    read_log(147, 1'b0);
    @(negedge i_clk);
    i_srst = 1'b1;
    i_nvm_present = 1'b1;
    i_nvm_locked = 1'b1;
    cycles(2);
    i_srst = 1'b0;
    cycles(6);
    check("restored", {o_log_present, o_log_locked}, 2'b11);
    read_log(147, 1'b0);
    check("kept cause", flrec_host_model_i.got[1], cause);
    for (int j = 0; j < 20; j++) begin
      check("slot five", flrec_host_model_i.got[108 + j], flrec_host_model_i.got[88 + j]);
      check("slot six", flrec_host_model_i.got[128 + j], flrec_host_model_i.got[88 + j]);
    end
    complete_run();
  end
endmodule : test_flrec_top
